/* File: sfl_cmd_read.sv */
// How it works
// - Accept 0Bh fast and 03h slow reads
// - Read data per falling clock, MSB first
// - Address counter auto-increments during the read
// - Wrap from top address to zero seamlessly
// - Chip select release ends read, output floats
// - Report clock limit 50/85/104 MHz per opcode
// - FFFFh dual, FFh quad continuous-read reset
// - Decode block erases and both chip erases
// - Program takes address then 1..256 bytes
// - Decode write enable/disable, volatile enable
// - Security erase/program take three address bytes
// - Security read: address, dummy, then data
// - Status reads return byte; write takes bytes
// - JEDEC ID three bytes; legacy ID two
// - Power-down B9h; ABh resumes, optional ID
// - Ignore unknown opcodes until chip select cycles
// - 24-bit MSB-first address, top nibble dropped
// - Sample on rising, drive on falling edge
// - 3Bh drives two bits per clock
`timescale 1ns/1ps
`include "sfl_regs.svh"

module sfl_cmd_read (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      cs_n,
  input  wire logic                      sck,
  input  wire logic                      si_in,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic [7:0]                status1,
  input  wire logic [7:0]                status2,
  input  wire logic [23:0]               jedec_id,
  input  wire logic [15:0]               legacy_id,
  input  wire logic [7:0]                power_id,
  output logic      [`SFL_ARRAY_AW-1:0]  mem_addr,
  output logic                           so,
  output logic                           so_oe_n,
  output logic                           si_out,
  output logic                           si_oe_n,
  output sfl_pkg::sfl_cmd_t              cmd,
  output sfl_pkg::sfl_wbyte_t            wr_data,
  output logic                           cmd_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  sfl_pin_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({cs_n, sck, si_in}),
    .level (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic cs_act;
  logic cs_up;
  logic sck_r;
  logic sck_f;
  logic si_s;

  assign cs_act = ~pin_lvl[2];
  assign cs_up  = pin_rise[2];
  assign sck_r  = pin_rise[1] & cs_act;
  assign sck_f  = pin_fall[1] & cs_act;
  assign si_s   = pin_lvl[0];

  ////////////////////////////////////////////////////////////////////////////
  // Opcode table

  function automatic sfl_pkg::sfl_info_t decode(input logic [7:0] op);
    sfl_pkg::sfl_info_t i;
    i.known   = 1'b1;
    i.addr_n  = 2'd0;
    i.dummy_n = 2'd0;
    i.dir     = sfl_pkg::SFL_DIR_NONE;
    i.max_mhz = `SFL_MHZ_OTHER;
    case (op)
      `SFL_OP_READ_SLOW: begin
        i.addr_n  = `SFL_ADDR_BYTES;
        i.dir     = sfl_pkg::SFL_DIR_ARRAY;
        i.max_mhz = `SFL_MHZ_SLOW;
      end
      `SFL_OP_READ_FAST, `SFL_OP_READ_DUAL, `SFL_OP_SEC_READ: begin
        i.addr_n  = `SFL_ADDR_BYTES;
        i.dummy_n = `SFL_DUMMY_ONE;
        i.dir     = sfl_pkg::SFL_DIR_ARRAY;
        i.max_mhz = `SFL_MHZ_FAST;
      end
      // Multi-bit address forms are reported only; a wider engine serves them
      `SFL_OP_READ_DIO, `SFL_OP_READ_QUAD, `SFL_OP_READ_QIO: begin
        i.addr_n  = `SFL_ADDR_BYTES;
        i.max_mhz = `SFL_MHZ_FAST;
      end
      `SFL_OP_ERASE_4K, `SFL_OP_ERASE_32K, `SFL_OP_ERASE_64K,
      `SFL_OP_SEC_ERASE, `SFL_OP_LEGACY_ID: begin
        i.addr_n = `SFL_ADDR_BYTES;
        if (op == `SFL_OP_LEGACY_ID) i.dir = sfl_pkg::SFL_DIR_RESP;
      end
      `SFL_OP_PROGRAM, `SFL_OP_SEC_PROG: begin
        i.addr_n = `SFL_ADDR_BYTES;
        i.dir    = sfl_pkg::SFL_DIR_IN;
      end
      `SFL_OP_ERASE_CHIP, `SFL_OP_ERASE_CHIP2, `SFL_OP_WR_EN, `SFL_OP_WR_DIS,
      `SFL_OP_WR_EN_VOL, `SFL_OP_POWER_DOWN, `SFL_OP_CRM_RESET: begin
        i.dir = sfl_pkg::SFL_DIR_NONE;
      end
      `SFL_OP_STAT_RD1, `SFL_OP_STAT_RD2, `SFL_OP_JEDEC_ID: begin
        i.dir = sfl_pkg::SFL_DIR_RESP;
      end
      `SFL_OP_STAT_WR: i.dir = sfl_pkg::SFL_DIR_IN;
      `SFL_OP_RESUME: begin
        i.dummy_n = `SFL_DUMMY_RESUME;
        i.dir     = sfl_pkg::SFL_DIR_RESP;
      end
      default: i.known = 1'b0;
    endcase
    return i;
  endfunction : decode

  function automatic sfl_pkg::sfl_state_t phase_after(input sfl_pkg::sfl_info_t i,
                                                      input logic addr_done,
                                                      input logic dummy_done);
    sfl_pkg::sfl_state_t s;
    s = sfl_pkg::SFL_ST_IGNORE;
    if (!addr_done && i.addr_n != 2'd0) s = sfl_pkg::SFL_ST_ADDR;
    else if (!dummy_done && i.dummy_n != 2'd0) s = sfl_pkg::SFL_ST_DUMMY;
    else if (i.dir == sfl_pkg::SFL_DIR_ARRAY || i.dir == sfl_pkg::SFL_DIR_RESP)
      s = sfl_pkg::SFL_ST_OUT;
    else if (i.dir == sfl_pkg::SFL_DIR_IN) s = sfl_pkg::SFL_ST_IN;
    return s;
  endfunction : phase_after

  ////////////////////////////////////////////////////////////////////////////
  // Shift-in and phase sequencing

  sfl_pkg::sfl_state_t state;
  sfl_pkg::sfl_info_t  info;
  sfl_pkg::sfl_info_t  op_info;
  logic [7:0]          opcode;
  logic [7:0]          in_sh;
  logic [7:0]          next_in;
  logic [2:0]          bit_cnt;
  logic [1:0]          byte_cnt;
  logic [23:0]         addr_sh;
  logic                byte_end;
  logic                last_addr;
  logic                last_dummy;
  logic                ready_evt;
  logic                started;

  assign next_in    = {in_sh[6:0], si_s};
  assign byte_end   = sck_r && bit_cnt == 3'd7;
  assign last_addr  = byte_end && state == sfl_pkg::SFL_ST_ADDR && byte_cnt == info.addr_n - 2'd1;
  assign last_dummy = byte_end && state == sfl_pkg::SFL_ST_DUMMY
                      && byte_cnt == info.dummy_n - 2'd1;

  always_comb begin
    op_info   = decode(next_in);
    ready_evt = last_addr;
    if (byte_end && state == sfl_pkg::SFL_ST_OPC && op_info.known
        && op_info.addr_n == 2'd0 && next_in != `SFL_OP_CRM_RESET)
      ready_evt = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst || !cs_act) begin
      bit_cnt <= 3'd0;
      in_sh   <= 8'h00;
    end else if (sck_r) begin
      bit_cnt <= bit_cnt + 3'd1;
      in_sh   <= next_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= sfl_pkg::SFL_ST_IDLE;
      info     <= '0;
      opcode   <= 8'h00;
      byte_cnt <= 2'd0;
      addr_sh  <= 24'h00_0000;
    end else if (!cs_act) begin
      state    <= sfl_pkg::SFL_ST_IDLE;
      byte_cnt <= 2'd0;
    end else if (byte_end) begin
      byte_cnt <= byte_cnt + 2'd1;
      unique case (state)
        sfl_pkg::SFL_ST_IDLE, sfl_pkg::SFL_ST_OPC: begin
          opcode   <= next_in;
          info     <= op_info;
          byte_cnt <= 2'd0;
          if (next_in == `SFL_OP_CRM_RESET) state <= sfl_pkg::SFL_ST_FF2;
          else if (!op_info.known) state <= sfl_pkg::SFL_ST_IGNORE;
          else state <= phase_after(op_info, 1'b0, 1'b0);
        end
        sfl_pkg::SFL_ST_FF2:
          state <= (next_in == `SFL_OP_CRM_RESET) ? sfl_pkg::SFL_ST_FFD
                                                  : sfl_pkg::SFL_ST_IGNORE;
        sfl_pkg::SFL_ST_ADDR: begin
          addr_sh <= {addr_sh[15:0], next_in};
          if (last_addr) begin
            byte_cnt <= 2'd0;
            state    <= phase_after(info, 1'b1, 1'b0);
          end
        end
        sfl_pkg::SFL_ST_DUMMY:
          if (last_dummy) begin
            byte_cnt <= 2'd0;
            state    <= phase_after(info, 1'b1, 1'b1);
          end
        sfl_pkg::SFL_ST_FFD, sfl_pkg::SFL_ST_OUT, sfl_pkg::SFL_ST_IN,
        sfl_pkg::SFL_ST_IGNORE: state <= state;
      endcase
    end else if (state == sfl_pkg::SFL_ST_IDLE) begin
      state <= sfl_pkg::SFL_ST_OPC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command report

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd      <= '0;
      cmd_done <= 1'b0;
      started  <= 1'b0;
    end else begin
      cmd.valid <= 1'b0;
      cmd_done  <= cs_up && started;
      if (!cs_act) started <= 1'b0;
      if (ready_evt) begin
        started         <= 1'b1;
        cmd.valid       <= 1'b1;
        cmd.opcode      <= last_addr ? opcode : next_in;
        cmd.addr        <= last_addr ? {addr_sh[11:0], next_in} : '0;
        cmd.max_mhz     <= last_addr ? info.max_mhz : op_info.max_mhz;
        cmd.dual_reset  <= 1'b0;
      end else if (cs_up && (state == sfl_pkg::SFL_ST_FF2 || state == sfl_pkg::SFL_ST_FFD)) begin
        // Length is only known at release, so the reset is reported then
        cmd.valid      <= 1'b1;
        cmd.opcode     <= `SFL_OP_CRM_RESET;
        cmd.addr       <= '0;
        cmd.max_mhz    <= `SFL_MHZ_OTHER;
        cmd.dual_reset <= state == sfl_pkg::SFL_ST_FFD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Incoming data bytes

  logic [8:0] data_cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_data <= '0;
    end else begin
      wr_data.valid <= byte_end && state == sfl_pkg::SFL_ST_IN;
      if (byte_end && state == sfl_pkg::SFL_ST_IN) begin
        wr_data.data  <= next_in;
        wr_data.index <= data_cnt;
        wr_data.over  <= opcode == `SFL_OP_PROGRAM && data_cnt >= `SFL_PROG_MAX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing data

  logic [7:0] out_sh;
  logic [2:0] out_bit;
  logic [7:0] resp_byte;
  logic [7:0] src;
  logic       dual;
  logic       load;

  assign dual = opcode == `SFL_OP_READ_DUAL;
  assign load = out_bit == 3'd0;

  always_comb begin
    unique case (opcode)
      `SFL_OP_STAT_RD1: resp_byte = status1;
      `SFL_OP_STAT_RD2: resp_byte = status2;
      `SFL_OP_JEDEC_ID: begin
        unique case (data_cnt[1:0])
          2'd0:    resp_byte = jedec_id[23:16];
          2'd1:    resp_byte = jedec_id[15:8];
          default: resp_byte = jedec_id[7:0];
        endcase
      end
      `SFL_OP_LEGACY_ID: resp_byte = data_cnt[0] ? legacy_id[7:0] : legacy_id[15:8];
      default:           resp_byte = power_id;
    endcase
    src = load ? ((info.dir == sfl_pkg::SFL_DIR_ARRAY) ? mem_rdata : resp_byte) : out_sh;
  end

  always_ff @(posedge clk) begin
    if (rst || !cs_act) begin
      out_sh   <= 8'h00;
      out_bit  <= 3'd0;
      data_cnt <= 9'd0;
    end else if (sck_f && state == sfl_pkg::SFL_ST_OUT) begin
      out_sh   <= dual ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
      out_bit  <= out_bit + (dual ? 3'd2 : 3'd1);
      if (load && data_cnt != 9'h1FF) data_cnt <= data_cnt + 9'd1;
    end else if (byte_end && state == sfl_pkg::SFL_ST_IN && data_cnt != 9'h1FF) begin
      data_cnt <= data_cnt + 9'd1;
    end
  end

  // Array pointer; rdata is sampled at least one clock after each update
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr <= '0;
    end else if (last_addr) begin
      mem_addr <= {addr_sh[11:0], next_in};
    end else if (sck_f && state == sfl_pkg::SFL_ST_OUT && load
                 && info.dir == sfl_pkg::SFL_DIR_ARRAY) begin
      mem_addr <= mem_addr + `SFL_ADDR_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !cs_act) begin
      so      <= 1'b0;
      si_out  <= 1'b0;
      so_oe_n <= 1'b1;
      si_oe_n <= 1'b1;
    end else if (sck_f && state == sfl_pkg::SFL_ST_OUT) begin
      so      <= src[7];
      si_out  <= src[6];
      so_oe_n <= 1'b0;
      si_oe_n <= ~dual;
    end else if (state != sfl_pkg::SFL_ST_OUT) begin
      so_oe_n <= 1'b1;
      si_oe_n <= 1'b1;
    end
  end

endmodule : sfl_cmd_read

/* File: sfl_cmd_read_assertions.sv */
`timescale 1ns/1ps
`include "sfl_regs.svh"

module sfl_cmd_read_chk (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     cs_n,
  input wire logic                     sck,
  input wire logic                     si_in,
  input wire logic [7:0]               mem_rdata,
  input wire logic [7:0]               status1,
  input wire logic [7:0]               status2,
  input wire logic [23:0]              jedec_id,
  input wire logic [15:0]              legacy_id,
  input wire logic [7:0]               power_id,
  input wire logic [`SFL_ARRAY_AW-1:0] mem_addr,
  input wire logic                     so,
  input wire logic                     so_oe_n,
  input wire logic                     si_out,
  input wire logic                     si_oe_n,
  input wire sfl_pkg::sfl_cmd_t        cmd,
  input wire sfl_pkg::sfl_wbyte_t      wr_data,
  input wire logic                     cmd_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // Five cycles cover the two sync stages plus the output flop
  property p_so_off; cs_n [*5] |-> so_oe_n; endproperty
  a_so_off: assert property (p_so_off) else $error("so driven while deselected");
  property p_si_off; cs_n [*5] |-> si_oe_n; endproperty
  a_si_off: assert property (p_si_off) else $error("si driven while deselected");
  property p_si_pair; !si_oe_n |-> !so_oe_n; endproperty
  a_si_pair: assert property (p_si_pair) else $error("si driven alone");
  property p_slow;
    cmd.valid && cmd.opcode == 8'h03 |-> cmd.max_mhz == `SFL_MHZ_SLOW;
  endproperty
  a_slow: assert property (p_slow) else $error("slow read limit wrong");
  property p_fast;
    cmd.valid && cmd.opcode == 8'h0B |-> cmd.max_mhz == `SFL_MHZ_FAST;
  endproperty
  a_fast: assert property (p_fast) else $error("fast read limit wrong");
  property p_other;
    cmd.valid && cmd.opcode == 8'h06 |-> cmd.max_mhz == `SFL_MHZ_OTHER;
  endproperty
  a_other: assert property (p_other) else $error("command limit wrong");
  property p_dual; cmd.valid && cmd.dual_reset |-> cmd.opcode == 8'hFF; endproperty
  a_dual: assert property (p_dual) else $error("dual reset flag on other opcode");
  property p_quiet; cs_n [*6] |-> !cmd.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("command while deselected");
  property p_done; cmd_done |-> cs_n && $past(cs_n); endproperty
  a_done: assert property (p_done) else $error("done without release");
  // Loads land with a report; any other move must be one step, wrapping at the top
  property p_step;
    !cmd.valid && !$past(cmd.valid) && !$past(cmd.valid, 2) && mem_addr != $past(mem_addr)
      |-> mem_addr == $past(mem_addr) + `SFL_ADDR_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address counter jumped");

  c_slow: cover property (cmd.valid && cmd.opcode == 8'h03);
  c_wrap: cover property (mem_addr == 20'h0_0000 && $past(mem_addr) == 20'hF_FFFF);
  c_done: cover property (cmd_done);
endmodule : sfl_cmd_read_chk

bind sfl_cmd_read sfl_cmd_read_chk u_chk (
  .clk, .rst, .cs_n, .sck, .si_in, .mem_rdata, .status1, .status2, .jedec_id, .legacy_id,
  .power_id, .mem_addr, .so, .so_oe_n, .si_out, .si_oe_n, .cmd, .wr_data, .cmd_done
);

/* File: sfl_host_model.sv */
`timescale 1ns/1ps

module sfl_host_model (
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_in
);
  // Set for mode 3: clock rests high outside frames
  logic idle_hi;

  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b0;
    idle_hi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Odd offset keeps sck unrelated in phase to clk
  task automatic open_frame();
    sck = idle_hi;
    #5.3 cs_n = 1'b0;
    #20;
  endtask : open_frame

  // Reads late in high phase: device answers some clk after the fall
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si  = b[i];
      #16 sck = 1'b1;
      #15 r[i] = so_in;
      #1;
    end
  endtask : xfer

  // May be called after a partial byte
  task automatic close_frame();
    sck = idle_hi;
    #20 cs_n = 1'b1;
    si = ~si;
    #60;
  endtask : close_frame
endmodule : sfl_host_model

/* File: sfl_pin_sync.sv */
`timescale 1ns/1ps

module sfl_pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  if (W < 1) begin : g_bad_width
    $error("sfl_pin_sync: W must be at least 1");
  end

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // One two-stage chain per pin; edges come from the second stage only
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta[g]  <= 1'b1;
        level[g] <= 1'b1;
        prev[g]  <= 1'b1;
      end else begin
        meta[g]  <= pin[g];
        level[g] <= meta[g];
        prev[g]  <= level[g];
      end
    end
    assign rise[g] = level[g] & ~prev[g];
    assign fall[g] = ~level[g] & prev[g];
  end

endmodule : sfl_pin_sync

/* File: sfl_pkg.sv */
package sfl_pkg;

  typedef enum logic [1:0] {
    SFL_DIR_NONE,
    SFL_DIR_ARRAY,
    SFL_DIR_RESP,
    SFL_DIR_IN
  } sfl_dir_t;

  typedef enum logic [3:0] {
    SFL_ST_IDLE,
    SFL_ST_OPC,
    SFL_ST_FF2,
    SFL_ST_FFD,
    SFL_ST_ADDR,
    SFL_ST_DUMMY,
    SFL_ST_OUT,
    SFL_ST_IN,
    SFL_ST_IGNORE
  } sfl_state_t;

  typedef struct packed {
    logic       known;
    logic [1:0] addr_n;
    logic [1:0] dummy_n;
    sfl_dir_t   dir;
    logic [6:0] max_mhz;
  } sfl_info_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [19:0] addr;
    logic [6:0]  max_mhz;
    logic        dual_reset;
  } sfl_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [8:0] index;
    logic       over;
  } sfl_wbyte_t;

endpackage : sfl_pkg

/* File: sfl_regs.svh */
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH

// Opcodes
`define SFL_OP_READ_FAST   8'h0B
`define SFL_OP_READ_SLOW   8'h03
`define SFL_OP_READ_DUAL   8'h3B
`define SFL_OP_READ_DIO    8'hBB
`define SFL_OP_READ_QUAD   8'h6B
`define SFL_OP_READ_QIO    8'hEB
`define SFL_OP_CRM_RESET   8'hFF
`define SFL_OP_ERASE_4K    8'h20
`define SFL_OP_ERASE_32K   8'h52
`define SFL_OP_ERASE_64K   8'hD8
`define SFL_OP_ERASE_CHIP  8'h60
`define SFL_OP_ERASE_CHIP2 8'hC7
`define SFL_OP_PROGRAM     8'h02
`define SFL_OP_WR_EN       8'h06
`define SFL_OP_WR_DIS      8'h04
`define SFL_OP_SEC_ERASE   8'h44
`define SFL_OP_SEC_PROG    8'h42
`define SFL_OP_SEC_READ    8'h48
`define SFL_OP_STAT_RD1    8'h05
`define SFL_OP_STAT_RD2    8'h35
`define SFL_OP_STAT_WR     8'h01
`define SFL_OP_WR_EN_VOL   8'h50
`define SFL_OP_JEDEC_ID    8'h9F
`define SFL_OP_LEGACY_ID   8'h90
`define SFL_OP_POWER_DOWN  8'hB9
`define SFL_OP_RESUME      8'hAB

// Clock limits in MHz per command class
`define SFL_MHZ_SLOW       7'd50
`define SFL_MHZ_FAST       7'd85
`define SFL_MHZ_OTHER      7'd104

// Byte counts of command phases
`define SFL_ADDR_BYTES     2'd3
`define SFL_DUMMY_ONE      2'd1
`define SFL_DUMMY_RESUME   2'd3
`define SFL_PROG_MAX       9'h100

// Array geometry
`define SFL_ARRAY_AW       20
`define SFL_ADDR_STEP      20'h0_0001

`endif

/* File: tb.sv */
`timescale 1ns/1ps
`include "sfl_regs.svh"

module tb;
  localparam logic [7:0]  ST1 = 8'hA5;
  localparam logic [7:0]  ST2 = 8'h3C;
  localparam logic [23:0] JID = 24'h12_3456; // Arbitrary
  localparam logic [15:0] LID = 16'hBEEF;    // Arbitrary
  localparam logic [7:0]  PID = 8'h5A;       // Arbitrary
  logic                     clk;
  logic                     rst;
  logic                     cs_n;
  logic                     sck;
  logic                     host_si;
  logic                     so_wire;
  logic                     si_wire;
  logic [7:0]               mem_rdata = 8'h00;
  logic [`SFL_ARRAY_AW-1:0] mem_addr;
  logic                     so;
  logic                     so_oe_n;
  logic                     si_out;
  logic                     si_oe_n;
  logic                     cmd_done;
  sfl_pkg::sfl_cmd_t        cmd;
  sfl_pkg::sfl_cmd_t        last_cmd;
  sfl_pkg::sfl_wbyte_t      wr_data;
  sfl_pkg::sfl_wbyte_t      last_wr;
  int                       err_count;
  int                       tests_run;
  int                       n_cmd;
  int                       n_wr;
  int                       n_done;
  int                       n_oe;
  logic [7:0]               si_cap = 8'h00;

  // Released line shows the wrong level so stray reads fail
  assign so_wire = so_oe_n ? ~so : so;
  assign si_wire = si_oe_n ? host_si : si_out;

  sfl_host_model host (.cs_n(cs_n), .sck(sck), .si(host_si), .so_in(so_wire));

  sfl_cmd_read dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si_in(si_wire), .mem_rdata(mem_rdata),
    .status1(ST1), .status2(ST2), .jedec_id(JID), .legacy_id(LID), .power_id(PID),
    .mem_addr(mem_addr), .so(so), .so_oe_n(so_oe_n), .si_out(si_out), .si_oe_n(si_oe_n),
    .cmd(cmd), .wr_data(wr_data), .cmd_done(cmd_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h9};
  endfunction : pat

  function automatic logic [6:0] mhz(input logic [7:0] op);
    case (op)
      8'h03: return `SFL_MHZ_SLOW;
      8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h48: return `SFL_MHZ_FAST;
      default: return `SFL_MHZ_OTHER;
    endcase
  endfunction : mhz

  function automatic bit has_addr(input logic [7:0] op);
    return op inside {8'h02, 8'h03, 8'h0B, 8'h20, 8'h52, 8'hD8, 8'h44, 8'h42, 8'h48,
                      8'h90, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
  endfunction : has_addr

  // Array model answers one clk after the address
  always @(posedge clk) begin
    mem_rdata <= pat(mem_addr);
    if (cmd.valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd;
    end
    if (wr_data.valid === 1'b1) begin
      n_wr++;
      last_wr = wr_data;
    end
    if (cmd_done === 1'b1) n_done++;
    if (so_oe_n === 1'b0) n_oe++;
  end

  // Second data line of the dual read, taken at each rising sck edge
  always @(posedge sck) begin
    if (si_oe_n === 1'b0) si_cap <= {si_cap[6:0], si_out};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic send_hdr(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    host.open_frame();
    host.xfer(op, 8, r);
    if (has_addr(op)) for (int i = 2; i >= 0; i--) host.xfer(a[8*i+:8], 8, r);
    if (op inside {8'h0B, 8'h3B, 8'h48}) host.xfer(8'h00, 8, r);
    if (op == 8'hAB) repeat (3) host.xfer(8'h00, 8, r);
  endtask : send_hdr

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_read(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [7:0] r;
    int         c;
    int         d;
    c = n_cmd;
    d = n_done;
    send_hdr(op, a);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, 8, r);
      chk(r, pat(a[19:0] + k));
    end
    host.xfer(8'h00, 3, r);
    host.close_frame();
    chk(n_cmd, c + 1);
    chk(last_cmd.opcode, op);
    chk(last_cmd.addr, a[19:0]);
    chk(last_cmd.max_mhz, mhz(op));
    chk(so_oe_n, 1'b1);
    chk(n_done, d + 1);
  endtask : t_read

  task automatic t_resp(input logic [7:0] op, input logic [23:0] exp, input int n);
    logic [7:0] r;
    int         c;
    c = n_cmd;
    send_hdr(op, 24'h00_0000);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, 8, r);
      chk(r, exp[8*(n-1-k)+:8]);
    end
    host.close_frame();
    chk(n_cmd, c + 1);
  endtask : t_resp

  task automatic t_table();
    logic [7:0] ops [20] = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h06, 8'h04, 8'h50,
                             8'h44, 8'h42, 8'h48, 8'h01, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h90,
                             8'hB9, 8'hAB};
    int         c;
    foreach (ops[i]) begin
      c = n_cmd;
      send_hdr(ops[i], 24'h00_0120);
      host.close_frame();
      chk(n_cmd, c + 1);
      chk(last_cmd.opcode, ops[i]);
      chk(last_cmd.max_mhz, mhz(ops[i]));
      if (has_addr(ops[i])) chk(last_cmd.addr, 20'h0_0120);
    end
  endtask : t_table

  task automatic t_prog();
    logic [7:0] r;
    int         c;
    c = n_wr;
    send_hdr(8'h02, 24'h00_0200);
    host.xfer(8'hC3, 8, r);
    host.xfer(8'h3C, 8, r);
    host.close_frame();
    chk(n_wr, c + 2);
    chk({last_wr.data, last_wr.index, last_wr.over}, {8'h3C, 9'h001, 1'b0});
  endtask : t_prog

  task automatic t_refuse();
    logic [7:0] r;
    int         c;
    int         o;
    c = n_cmd;
    o = n_oe;
    host.open_frame();
    host.xfer(8'h77, 8, r);
    repeat (5) host.xfer(8'h03, 8, r);
    host.close_frame();
    host.open_frame();
    host.xfer(8'h03, 8, r);
    host.xfer(8'h00, 8, r);
    host.close_frame();
    chk(n_cmd, c);
    chk(n_oe, o);
  endtask : t_refuse

  task automatic t_crm();
    logic [7:0] r;
    int         c;
    for (int k = 2; k >= 1; k--) begin
      c = n_cmd;
      host.open_frame();
      repeat (k) host.xfer(8'hFF, 8, r);
      host.close_frame();
      chk(n_cmd, c + 1);
      chk({last_cmd.opcode, last_cmd.dual_reset}, {8'hFF, k == 2});
    end
  endtask : t_crm

  task automatic t_dual();
    logic [7:0] r;
    logic [7:0] p;
    p = pat(20'h0_0040);
    send_hdr(8'h3B, 24'h00_0040);
    host.xfer(8'h00, 4, r);
    host.close_frame();
    chk(r[7:4], {p[7], p[5], p[3], p[1]});
    chk(si_cap[3:0], {p[6], p[4], p[2], p[0]});
    chk(si_oe_n, 1'b1);
  endtask : t_dual

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    t_read(8'h03, 24'hFF_FFFE, 4);
    t_read(8'h0B, 24'h01_2345, 2);
    host.idle_hi = 1'b1;
    t_read(8'h03, 24'h0A_BCDE, 2);
    host.idle_hi = 1'b0;
    t_resp(8'h05, {16'h0000, ST1}, 1);
    t_resp(8'h35, {16'h0000, ST2}, 1);
    t_resp(8'h9F, JID, 3);
    t_resp(8'h90, {8'h00, LID}, 2);
    t_resp(8'hAB, {16'h0000, PID}, 1);
    t_table();
    t_prog();
    t_refuse();
    t_crm();
    t_dual();
    complete_run();
  end

  // Whole sequence needs about 40 us
  initial begin
    #200us;
    err_count++;
    complete_run();
  end
endmodule : tb
